// >>> hw/pcss_map.svh
// Constants for the PC Card socket strobe generator.
// Function
// RULE_01: Attribute select stays high for every common memory access.
// RULE_02: I/O cards ignore I/O strobes while attribute select is inactive.
// RULE_03: Attribute select low with write or output enable reaches attribute memory.
// RULE_04: Attribute select low with I/O read or write reaches card I/O ports.
// RULE_05: One attribute select and one output enable serve all sockets.
// RULE_06: Output enable goes low to gate memory read data from the card.
// RULE_07: Transceiver direction is high for reads, low for writes, both bytes.
// RULE_08: Transceiver direction resets to the write direction, low.
// RULE_09: Transceiver direction steers only the card-socket transceivers, not IDE.
// RULE_10: A socket's chip enables are driven only while that socket is enabled.
// RULE_11: First chip enable picks the even byte, second the odd byte.
// RULE_12: Each socket's write enable gates write data into memory cards.
// RULE_13: The write enable pin doubles as the program strobe.
// RULE_14: Ready input means ready/busy on memory cards, interrupt on I/O cards.
// RULE_15: A memory card holds ready low while finishing a previous write.
// RULE_16: A memory card drives ready high when it accepts a new command.
// RULE_17: An I/O card asserts its interrupt line when it needs service.
// RULE_18: An I/O card holds the interrupt line inactive when nothing pends.
// RULE_19: Each socket's ready/interrupt level is readable in its status word.
// RULE_20: I/O read and write strobes with attribute select gate I/O data.
// RULE_21: Chip enables of at most one socket are active in any cycle.
`ifndef PCSS_MAP_SVH
`define PCSS_MAP_SVH
`define PCSS_SOCKETS 4
`define PCSS_SETUP_CYC 2
`define PCSS_STROBE_CYC 4
`define PCSS_HOLD_CYC 2
`define PCSS_CNT_W 4
`define PCSS_XCVR_RST 1'b0
`endif

// >>> hw/pcss_pkg.sv
// Types for the PC Card socket strobe generator.
package pcss_pkg;
    typedef enum logic [1:0] {
        PCSS_MEM = 2'b00,
        PCSS_ATTR = 2'b01,
        PCSS_IO = 2'b10
    } pcss_space_e;
    typedef enum logic [1:0] {
        PCSS_IDLE = 2'b00,
        PCSS_SETUP = 2'b01,
        PCSS_STROBE = 2'b10,
        PCSS_HOLD = 2'b11
    } pcss_state_e;
endpackage

// >>> hw/pcss_strobes.sv
// Card-side strobe sequencer for up to four PC Card sockets.
`timescale 1ns/10ps
`include "pcss_map.svh"
module pcss_strobes #(
    parameter int SOCKETS = `PCSS_SOCKETS,
    parameter int SETUP_CYC = `PCSS_SETUP_CYC,
    parameter int STROBE_CYC = `PCSS_STROBE_CYC,
    parameter int HOLD_CYC = `PCSS_HOLD_CYC
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [1:0] req_socket,
    input wire logic [1:0] req_space,
    input wire logic req_write,
    input wire logic req_even,
    input wire logic req_odd,
    input wire logic [SOCKETS-1:0] sock_enable,
    input wire logic [SOCKETS-1:0] sock_is_io,
    output logic done,
    output logic sock_a_attr_select_n,
    output logic card_output_enable_n,
    output logic card_io_read_n,
    output logic card_io_write_n,
    output logic xcvr_direction,
    output logic [SOCKETS-1:0] even_byte_select_n,
    output logic [SOCKETS-1:0] odd_byte_select_n,
    output logic [SOCKETS-1:0] card_program_strobe_n,
    input wire logic [SOCKETS-1:0] card_ready_n_busy,
    output logic [SOCKETS-1:0] ready_level,
    output logic [SOCKETS-1:0] mem_card_ready,
    output logic [SOCKETS-1:0] io_card_irq
);
    typedef struct packed {
        pcss_pkg::pcss_state_e state;
        logic [`PCSS_CNT_W-1:0] cnt;
        logic [1:0] sock;
        pcss_pkg::pcss_space_e space;
        logic write;
        logic even;
        logic odd;
        logic done;
        logic attr_n;
        logic oe_n;
        logic card_io_read_n_n;
        logic card_io_write_n_n;
        logic dir;
        logic [SOCKETS-1:0] ce1_n;
        logic [SOCKETS-1:0] ce2_n;
        logic [SOCKETS-1:0] we_n;
        logic [SOCKETS-1:0] rdy_s1;
        logic [SOCKETS-1:0] rdy_s2;
    } pcss_state_s;

    pcss_state_s r;
    pcss_state_s next_r;

    localparam logic [`PCSS_CNT_W-1:0] SETUP_N = `PCSS_CNT_W'(SETUP_CYC - 1);
    localparam logic [`PCSS_CNT_W-1:0] STROBE_N = `PCSS_CNT_W'(STROBE_CYC - 1);
    localparam logic [`PCSS_CNT_W-1:0] HOLD_N = `PCSS_CNT_W'(HOLD_CYC - 1);

    // One-hot active-low select for the addressed socket only.
    function automatic logic [SOCKETS-1:0] sock_sel_n(input logic [1:0] s, input logic en);
        logic [SOCKETS-1:0] v;
        v = '1;
        if (en) begin
            v[s] = 1'b0;
        end
        return v;
    endfunction

    always_comb begin
        next_r = r;
        next_r.done = 1'b0;
        next_r.rdy_s1 = card_ready_n_busy;
        next_r.rdy_s2 = r.rdy_s1;
        unique case (r.state)
            pcss_pkg::PCSS_IDLE: begin
                if (req_valid) begin
                    next_r.sock = req_socket;
                    next_r.space = pcss_pkg::pcss_space_e'(req_space);
                    next_r.write = req_write;
                    next_r.even = req_even;
                    next_r.odd = req_odd;
                    next_r.cnt = SETUP_N;
                    next_r.state = pcss_pkg::PCSS_SETUP;
                    // Common memory keeps select high; attribute and I/O pull it low.
                    next_r.attr_n = (pcss_pkg::pcss_space_e'(req_space) == pcss_pkg::PCSS_MEM); // [RULE_01] [RULE_03] [RULE_04]
                    next_r.dir = ~req_write; // [RULE_07] [RULE_09]
                    // Chip enables only for an enabled socket, one socket at a time.
                    if (sock_enable[req_socket]) begin
                        next_r.ce1_n = sock_sel_n(req_socket, req_even); // [RULE_10] [RULE_11] [RULE_21]
                        next_r.ce2_n = sock_sel_n(req_socket, req_odd); // [RULE_10] [RULE_11] [RULE_21]
                    end
                end
            end
            pcss_pkg::PCSS_SETUP: begin
                next_r.cnt = r.cnt - 1'b1;
                if (r.cnt == '0) begin
                    next_r.cnt = STROBE_N;
                    next_r.state = pcss_pkg::PCSS_STROBE;
                    if (r.space == pcss_pkg::PCSS_IO) begin
                        next_r.card_io_read_n_n = r.write; // [RULE_20] [RULE_04]
                        next_r.card_io_write_n_n = ~r.write; // [RULE_20] [RULE_04]
                    end else if (r.write) begin
                        next_r.we_n = sock_sel_n(r.sock, sock_enable[r.sock]); // [RULE_12] [RULE_13]
                    end else begin
                        next_r.oe_n = 1'b0; // [RULE_06] [RULE_05]
                    end
                end
            end
            pcss_pkg::PCSS_STROBE: begin
                next_r.cnt = r.cnt - 1'b1;
                if (r.cnt == '0) begin
                    next_r.cnt = HOLD_N;
                    next_r.state = pcss_pkg::PCSS_HOLD;
                    next_r.oe_n = 1'b1;
                    next_r.card_io_read_n_n = 1'b1;
                    next_r.card_io_write_n_n = 1'b1;
                    next_r.we_n = '1;
                end
            end
            pcss_pkg::PCSS_HOLD: begin
                next_r.cnt = r.cnt - 1'b1;
                if (r.cnt == '0) begin
                    next_r.state = pcss_pkg::PCSS_IDLE;
                    next_r.ce1_n = '1;
                    next_r.ce2_n = '1;
                    next_r.attr_n = 1'b1;
                    next_r.dir = `PCSS_XCVR_RST;
                    next_r.done = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            r.state <= pcss_pkg::PCSS_IDLE;
            r.cnt <= '0;
            r.sock <= 2'h0;
            r.space <= pcss_pkg::PCSS_MEM;
            r.write <= 1'b0;
            r.even <= 1'b0;
            r.odd <= 1'b0;
            r.done <= 1'b0;
            r.attr_n <= 1'b1;
            r.oe_n <= 1'b1;
            r.card_io_read_n_n <= 1'b1;
            r.card_io_write_n_n <= 1'b1;
            r.dir <= `PCSS_XCVR_RST; // [RULE_08]
            r.ce1_n <= '1;
            r.ce2_n <= '1;
            r.we_n <= '1;
            r.rdy_s1 <= '1;
            r.rdy_s2 <= '1;
        end else begin
            r <= next_r;
        end
    end

    assign req_ready = (r.state == pcss_pkg::PCSS_IDLE);
    assign done = r.done;
    assign sock_a_attr_select_n = r.attr_n; // [RULE_05]
    assign card_output_enable_n = r.oe_n; // [RULE_05]
    assign card_io_read_n = r.card_io_read_n_n;
    assign card_io_write_n = r.card_io_write_n_n;
    assign xcvr_direction = r.dir;
    assign even_byte_select_n = r.ce1_n;
    assign odd_byte_select_n = r.ce2_n;
    assign card_program_strobe_n = r.we_n;
    assign ready_level = r.rdy_s2; // [RULE_19]

    genvar g;
    generate
        for (g = 0; g < SOCKETS; g++) begin : g_sock
            assign mem_card_ready[g] = ~sock_is_io[g] & r.rdy_s2[g]; // [RULE_14]
            assign io_card_irq[g] = sock_is_io[g] & ~r.rdy_s2[g]; // [RULE_14]
        end
    endgenerate
endmodule

// >>> sim/pcss_card_model.sv
// Behavioural model of memory and I/O PC Cards in four sockets.
`timescale 1ns/10ps
module pcss_card_model (
    input wire logic clk,
    input wire logic [3:0] program_strobe_n,
    input wire logic [3:0] is_io,
    input wire logic [3:0] irq_want,
    output logic [3:0] ready_n_busy
);
    logic [2:0] busy [4] = '{default: '0};
    always_ff @(posedge clk) begin
        for (int i = 0; i < 4; i++) busy[i] <= {busy[i][1:0], program_strobe_n[i] === 1'b0};
    end
    always_comb begin
        for (int i = 0; i < 4; i++) ready_n_busy[i] = is_io[i] ? ~irq_want[i] : ~|busy[i];
    end
endmodule

// >>> sim/pcss_strobes_props.sv
// Assertion checker for the PC Card socket strobe generator.
`timescale 1ns/10ps
module pcss_strobes_props #(
    parameter int SOCKETS = 4
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic [1:0] req_space,
    input wire logic sock_a_attr_select_n,
    input wire logic card_output_enable_n,
    input wire logic card_io_read_n,
    input wire logic card_io_write_n,
    input wire logic xcvr_direction,
    input wire logic [SOCKETS-1:0] even_byte_select_n,
    input wire logic [SOCKETS-1:0] odd_byte_select_n,
    input wire logic [SOCKETS-1:0] card_program_strobe_n,
    input wire logic [SOCKETS-1:0] sock_enable,
    input wire logic [SOCKETS-1:0] sock_is_io,
    input wire logic [SOCKETS-1:0] card_ready_n_busy,
    input wire logic [SOCKETS-1:0] ready_level,
    input wire logic [SOCKETS-1:0] mem_card_ready,
    input wire logic [SOCKETS-1:0] io_card_irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_mem_take;
        req_valid && req_ready && req_space == 2'h0;
    endsequence
    a_mem_attr_high: assert property (s_mem_take |=> sock_a_attr_select_n [*7])
        else $error("attribute select low in a common memory cycle");
    a_oe_is_read: assert property (!card_output_enable_n |-> xcvr_direction)
        else $error("output enable without read direction");
    a_we_is_write: assert property (!(&card_program_strobe_n) |-> !xcvr_direction)
        else $error("write enable without write direction");
    a_io_has_attr: assert property (!(card_io_read_n && card_io_write_n) |-> !sock_a_attr_select_n)
        else $error("I/O strobe with attribute select high");
    a_oe_not_io: assert property (!card_output_enable_n |-> card_io_read_n && card_io_write_n)
        else $error("output enable together with an I/O strobe");
    a_one_socket: assert property ($onehot0(~(even_byte_select_n & odd_byte_select_n)))
        else $error("chip enables of two sockets at once");
    a_ce_enabled: assert property (((~even_byte_select_n | ~odd_byte_select_n) & ~sock_enable) == '0)
        else $error("chip enable on a disabled socket");
    a_dir_reset: assert property ($fell(sys_rst) |-> !xcvr_direction)
        else $error("direction not low after reset");
    a_status_sync: assert property (!$past(sys_rst) && !$past(sys_rst, 2) |-> ready_level == $past(card_ready_n_busy, 2))
        else $error("status level does not follow the pin");
    a_irq_map: assert property ((io_card_irq & sock_is_io) == (~ready_level & sock_is_io)
        && (mem_card_ready & ~sock_is_io) == (ready_level & ~sock_is_io))
        else $error("ready or interrupt meaning wrong for card type");
endmodule
bind pcss_strobes pcss_strobes_props #(.SOCKETS(SOCKETS)) i_pcss_strobes_props (.*);

// >>> sim/tb_pcss_strobes.sv
// Self-checking testbench for the PC Card socket strobe generator.
`timescale 1ns/10ps
module tb_pcss_strobes;
    logic clk = 0, sys_rst = 1, req_valid = 0, req_write = 0, req_even = 0, req_odd = 0;
    logic [1:0] req_socket = '0, req_space = '0;
    logic [3:0] sock_enable = '0, sock_is_io = '0, irq_want = '0, rdy, ebs, obs, pgm, irq, sel;
    logic req_ready, done, attr_n, oe_n, card_io_read_n_n, card_io_write_n_n, dir, en, io;
    logic [20:0] acc = '0, e, exp_q [$];
    int failures = 0, tests_run = 0, cycles = 0, seed = 69707;
    always #5 clk = ~clk;
    pcss_strobes i_pcss_strobes (.clk(clk), .sys_rst(sys_rst), .req_valid(req_valid),
        .req_ready(req_ready), .req_socket(req_socket), .req_space(req_space),
        .req_write(req_write), .req_even(req_even), .req_odd(req_odd),
        .sock_enable(sock_enable), .sock_is_io(sock_is_io), .done(done),
        .sock_a_attr_select_n(attr_n), .card_output_enable_n(oe_n), .card_io_read_n(card_io_read_n_n),
        .card_io_write_n(card_io_write_n_n), .xcvr_direction(dir), .even_byte_select_n(ebs),
        .odd_byte_select_n(obs), .card_program_strobe_n(pgm), .card_ready_n_busy(rdy),
        .ready_level(), .mem_card_ready(), .io_card_irq(irq));
    pcss_card_model i_pcss_card_model (.clk(clk), .program_strobe_n(pgm),
        .is_io(sock_is_io), .irq_want(irq_want), .ready_n_busy(rdy));
    task automatic check(input string what, input logic [20:0] x, input logic [20:0] g);
        tests_run++;
        if (g !== x) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, x, g);
        end
    endtask
    task automatic close_out();
        if (failures == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Strobes seen during a card cycle are gathered and judged at its done pulse.
    always @(posedge clk) begin
        cycles++;
        if (cycles > 3000) begin
            failures++;
            close_out();
        end
        if (done === 1'b1) begin
            e = exp_q.size() > 0 ? exp_q.pop_front() : 'x;
            check("cycle", e, {acc[20:4], irq});
            acc = '0;
        end else if (sys_rst !== 1'b1) begin
            // Outputs are unknown until the first reset edge, so nothing is gathered while sys_rst is held high.
            acc = acc | {~oe_n, ~card_io_read_n_n, ~card_io_write_n_n, ~attr_n, dir, ~pgm, ~ebs, ~obs, 4'h0};
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        #1 sys_rst = 0;
        for (int n = 0; n < 48; n++) begin
            if (n % 4 == 0) begin
                req_valid = 0;
                repeat (12) @(posedge clk);
                #1 {sock_enable, sock_is_io, irq_want} = 12'($random(seed));
            end
            {req_socket, req_write, req_even, req_odd} = 5'($random(seed));
            req_space = 2'(n % 3);
            sel = 4'h1 << req_socket;
            en = sock_enable[req_socket];
            io = req_space == 2'h2;
            exp_q.push_back({!req_write && !io, !req_write && io, req_write && io,
                req_space != 2'h0, !req_write, (req_write && !io && en) ? sel : 4'h0,
                (en && req_even) ? sel : 4'h0, (en && req_odd) ? sel : 4'h0, sock_is_io & irq_want});
            req_valid = 1;
            while (req_ready !== 1'b1) @(posedge clk) #1;
            @(posedge clk) #1;
        end
        req_valid = 0;
        repeat (12) @(posedge clk);
        close_out();
    end
endmodule
